// File: rtl/pit_defines.vh
// Constants for the periodic interrupt timer: register map, field layout and reset values.
`ifndef PIT_DEFINES_VH
`define PIT_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PIT_ADDR_W        16
`define PIT_OFF_STATUS    16'h004b
`define PIT_OFF_CNT_HI    16'h004c
`define PIT_OFF_CNT_LO    16'h004d
`define PIT_OFF_MOD_HI    16'h004e
`define PIT_OFF_MOD_LO    16'h004f

// ----------------------------------------------------------------------------
// Status and control field positions
// ----------------------------------------------------------------------------
`define PIT_BIT_OVF       7
`define PIT_BIT_IRQ_EN    6
`define PIT_BIT_HALT      5
`define PIT_BIT_CLEAR     4
`define PIT_PS_HI         2
`define PIT_PS_LO         0

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define PIT_CNT_RESET     16'h0000
`define PIT_MOD_RESET     16'hffff
`define PIT_PS_RESET      3'h0
`define PIT_PS_MAX        3'h6
`define PIT_BYTE_ZERO     8'h00

`endif

// File: rtl/pit_timer.v
// Periodic interrupt timer: prescaler, 16-bit modulo counter and byte-wide register port.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "pit_defines.vh"

module pit_timer #(
  parameter CNT_W = 16,
  parameter PS_W  = 6
) (
  // Clock and reset.
  input  wire                   clk_in,
  input  wire                   rstn_in,
  // Register port.
  input  wire [`PIT_ADDR_W-1:0] addr_in,
  input  wire [7:0]             wdata_in,
  input  wire                   wr_in,
  input  wire                   rd_in,
  output reg  [7:0]             rdata_out,
  // System state inputs.
  input  wire                   wait_mode_in,
  input  wire                   stop_mode_in,
  input  wire                   break_in,
  input  wire                   break_flag_clear_enable_in,
  // Interrupt request.
  output reg                    irq_out
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [CNT_W-1:0] count;
  reg  [PS_W-1:0]  prescale;
  reg  [2:0]       prescale_select;
  reg              overflow_flag;
  reg              overflow_irq_enable;
  reg              count_halt;
  reg              clear_armed;
  reg  [7:0]       modulo_high;
  reg  [7:0]       modulo_low;
  reg  [7:0]       modulo_high_stage;
  reg              modulo_pending;
  reg  [7:0]       low_latch;
  reg              low_latched;

  wire             bus_ok;
  wire             wr_ok;
  wire             rd_ok;
  wire             clr_write;
  wire             tick;
  wire             run;
  wire             match;
  wire             overflow_event;
  wire             protect;
  wire [CNT_W-1:0] modulo_value;

  // Full-width reset pattern, sliced into bytes so no bits are dropped silently.
  localparam [15:0] modulo_reset = `PIT_MOD_RESET;

  // Selects the prescaler tap; a tap is reached when all lower bits are one.
  function pit_tick;
    input [2:0]      sel;
    input [PS_W-1:0] ps;
    reg   [2:0]      s;
    begin
      s = (sel > `PIT_PS_MAX) ? `PIT_PS_MAX : sel;
      if (s == `PIT_PS_RESET) begin
        pit_tick = 1'b1;
      end else begin
        pit_tick = &(ps | ({PS_W{1'b1}} << s));
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  // Registers are invisible in wait and stop mode.
  assign bus_ok    = ~wait_mode_in & ~stop_mode_in;
  assign wr_ok     = wr_in & bus_ok;
  assign rd_ok     = rd_in & bus_ok;
  assign protect   = break_in & ~break_flag_clear_enable_in;
  assign clr_write = wr_ok & (addr_in == `PIT_OFF_STATUS) & wdata_in[`PIT_BIT_CLEAR];
  assign run       = ~count_halt & ~break_in & ~stop_mode_in;
  assign tick      = run & pit_tick(prescale_select, prescale);
  assign modulo_value = {modulo_high, modulo_low};
  assign match     = (count == modulo_value);
  // A match on a counting tick is the overflow; held off while modulo is half loaded.
  assign overflow_event = tick & match & ~modulo_pending & ~clr_write;

  // --------------------------------------------------------------------------
  // Prescaler and counter
  // --------------------------------------------------------------------------
  // Count clear zeroes counter and prescaler, also when halt is set in the same write.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      count    <= `PIT_CNT_RESET;
      prescale <= {PS_W{1'b0}};
    end else if (clr_write) begin
      count    <= `PIT_CNT_RESET;
      prescale <= {PS_W{1'b0}};
    end else if (run) begin
      prescale <= prescale + 1'b1;
      if (tick) begin
        if (match) begin
          count <= `PIT_CNT_RESET;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status and control
  // --------------------------------------------------------------------------
  // The flag clear needs an armed read; a new overflow disarms and wins.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      overflow_flag       <= 1'b0;
      overflow_irq_enable <= 1'b0;
      count_halt          <= 1'b1;
      prescale_select     <= `PIT_PS_RESET;
      clear_armed         <= 1'b0;
    end else begin
      if (wr_ok && addr_in == `PIT_OFF_STATUS) begin
        overflow_irq_enable <= wdata_in[`PIT_BIT_IRQ_EN];
        count_halt          <= wdata_in[`PIT_BIT_HALT];
        prescale_select     <= wdata_in[`PIT_PS_HI:`PIT_PS_LO];
      end
      if (overflow_event) begin
        overflow_flag <= 1'b1;
        clear_armed   <= 1'b0;
      end else if (wr_ok && addr_in == `PIT_OFF_STATUS && !protect) begin
        if (clear_armed && !wdata_in[`PIT_BIT_OVF]) begin
          overflow_flag <= 1'b0;
        end
        clear_armed <= 1'b0;
      end else if (rd_ok && addr_in == `PIT_OFF_STATUS && !protect && overflow_flag) begin
        clear_armed <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Modulo registers
  // --------------------------------------------------------------------------
  // The high byte is staged and takes effect together with the low byte.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      modulo_high       <= modulo_reset[15:8];
      modulo_low        <= modulo_reset[7:0];
      modulo_high_stage <= modulo_reset[15:8];
      modulo_pending    <= 1'b0;
    end else if (wr_ok && addr_in == `PIT_OFF_MOD_HI) begin
      modulo_high_stage <= wdata_in;
      modulo_pending    <= 1'b1;
    end else if (wr_ok && addr_in == `PIT_OFF_MOD_LO) begin
      modulo_high    <= modulo_high_stage;
      modulo_low     <= wdata_in;
      modulo_pending <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Coherent counter read
  // --------------------------------------------------------------------------
  // The first high-byte read latches the low byte; it is released by a low read.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      low_latch   <= `PIT_BYTE_ZERO;
      low_latched <= 1'b0;
    end else if (rd_ok && addr_in == `PIT_OFF_CNT_HI && !low_latched) begin
      low_latch   <= count[7:0];
      low_latched <= 1'b1;
    end else if (rd_ok && addr_in == `PIT_OFF_CNT_LO) begin
      low_latched <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Read data and interrupt
  // --------------------------------------------------------------------------
  // Read data stand for one cycle after the strobe and read zero otherwise.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_out <= `PIT_BYTE_ZERO;
    end else if (rd_ok) begin
      case (addr_in)
        `PIT_OFF_STATUS: rdata_out <= {overflow_flag, overflow_irq_enable, count_halt,
                                       1'b0, 1'b0, prescale_select};
        `PIT_OFF_CNT_HI: rdata_out <= count[15:8];
        `PIT_OFF_CNT_LO: rdata_out <= low_latched ? low_latch : count[7:0];
        `PIT_OFF_MOD_HI: rdata_out <= modulo_pending ? modulo_high_stage : modulo_high;
        `PIT_OFF_MOD_LO: rdata_out <= modulo_low;
        default:         rdata_out <= `PIT_BYTE_ZERO;
      endcase
    end else begin
      rdata_out <= `PIT_BYTE_ZERO;
    end
  end

  // Level request while flag and enable are both set; masked during a half load.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= overflow_flag & overflow_irq_enable & ~modulo_pending;
    end
  end

endmodule // pit_timer
`default_nettype wire

// File: test/pit_cpu_model.sv
// Processor-side master of the timer register port.
`timescale 1ns/100ps
`default_nettype none
module pit_cpu_model (
  // Clock.
  input  wire logic        clk_in,
  // Request.
  output var  logic [15:0] addr_out,
  output var  logic [7:0]  wdata_out,
  output var  logic        wr_out,
  output var  logic        rd_out,
  // Answer.
  input  wire logic [7:0]  rdata_in
);
  // The bus is idle at time zero.
  initial {addr_out, wdata_out, wr_out, rd_out} = 26'h0;
  // One write cycle; strobe, address and data change just after an edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    {addr_out, wdata_out, wr_out} <= {a, v, 1'b1};
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
  // One read cycle; data are taken in the cycle after the read edge.
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_in);
    {addr_out, rd_out} <= {a, 1'b1};
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 v = rdata_in;
  endtask
endmodule // pit_cpu_model
`default_nettype wire

// File: test/pit_timer_chk.sv
// Checker on the timer ports.
`timescale 1ns/100ps
`default_nettype none
`include "pit_defines.vh"
module pit_timer_chk (
  // Watched ports.
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        wait_mode_in,
  input wire logic        stop_mode_in,
  input wire logic        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // An access is taken only outside wait and stop.
  wire go = !wait_mode_in && !stop_mode_in;
  wire ws = wr_in && go && addr_in == `PIT_OFF_STATUS;
  property p_sc_rb; ws ##1 !wr_in ##1 rd_in && go && addr_in == `PIT_OFF_STATUS |=>
    rdata_out[6:5] == $past(wdata_in[6:5], 3) && rdata_out[2:0] == $past(wdata_in[2:0], 3);
  endproperty
  a_sc_rb: assert property (p_sc_rb) else $error("status readback wrong");
  property p_clr_rd0; rd_in && go && addr_in == `PIT_OFF_STATUS |=> rdata_out[4:3] == 2'b00;
  endproperty
  a_clr_rd0: assert property (p_clr_rd0) else $error("clear bit read nonzero");
  property p_halt_clr; ws && wdata_in[5:4] == 2'b11 ##1 !wr_in ##1
    rd_in && go && addr_in == `PIT_OFF_CNT_HI |=> rdata_out == 8'h00; endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("count not held at zero");
  property p_wait_rd; rd_in && wait_mode_in |=> rdata_out == 8'h00; endproperty
  a_wait_rd: assert property (p_wait_rd) else $error("read taken in wait");
  property p_stop_rd; rd_in && stop_mode_in |=> rdata_out == 8'h00; endproperty
  a_stop_rd: assert property (p_stop_rd) else $error("read taken in stop");
  property p_stop_irq; stop_mode_in [*3] |-> $stable(irq_out); endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("request moved in stop");
  property p_irq_hold; irq_out && !$past(wr_in) |=> irq_out; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped alone");
  property p_irq_en; ws && !wdata_in[6] |-> ##2 !irq_out; endproperty
  a_irq_en: assert property (p_irq_en) else $error("request without enable");
  property p_mod_pend; wr_in && go && addr_in == `PIT_OFF_MOD_HI |-> ##2 !irq_out; endproperty
  a_mod_pend: assert property (p_mod_pend) else $error("request while modulo pending");
  // Main scenarios seen.
  c_irq: cover property ($rose(irq_out));
  c_clr: cover property (ws && wdata_in[4]);
  c_stop: cover property (rd_in && stop_mode_in);
endmodule // pit_timer_chk
bind pit_timer pit_timer_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .wait_mode_in(wait_mode_in), .stop_mode_in(stop_mode_in), .irq_out(irq_out));
`default_nettype wire

// File: test/tb_top.sv
// Self-checking testbench of the timer.
`timescale 1ns/100ps
`default_nettype none
`include "pit_defines.vh"
module tb_top;
  localparam logic [15:0] SC = `PIT_OFF_STATUS, CH = `PIT_OFF_CNT_HI, CL = `PIT_OFF_CNT_LO;
  localparam logic [15:0] MH = `PIT_OFF_MOD_HI, ML = `PIT_OFF_MOD_LO;
  logic        clk_in = 1'b0, rstn_in = 1'b0, wt = 1'b0, st = 1'b0, brk = 1'b0, break_flag_clear_enable = 1'b0;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, d, d0;
  logic        wr, rd, irq;
  int          n_fail = 0, comparisons = 0;
  // The 10 MHz clock.
  always #50 clk_in = ~clk_in;
  pit_cpu_model u_cpu (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata));
  pit_timer u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .wait_mode_in(wt), .stop_mode_in(st),
    .break_in(brk), .break_flag_clear_enable_in(break_flag_clear_enable), .irq_out(irq));
  // Compares and counts.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e, input string nm);
    u_cpu.rd(a, d);
    chk(nm, e, d);
  endtask
  // Runs until an overflow request, then halts with the flag kept.
  task automatic ovf();
    u_cpu.wr(SC, 8'h40);
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk_in);
    chk("irq", 8'h01, {7'h00, irq});
    u_cpu.wr(SC, 8'h60);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    rc(SC, 8'h20, "status");
    rc(CH, 8'h00, "cnt_hi");
    rc(CL, 8'h00, "cnt_lo");
    rc(MH, 8'hff, "mod_hi");
    rc(ML, 8'hff, "mod_lo");
    rc(16'h0050, 8'h00, "unmapped");
    u_cpu.wr(CH, 8'h5a);
    rc(CH, 8'h00, "cnt_ro");
    u_cpu.wr(SC, 8'h30);
    rc(CH, 8'h00, "halt_clr");
    rc(SC, 8'h20, "clr_bit");
    u_cpu.wr(MH, 8'h00);
    u_cpu.wr(ML, 8'h03);
    rc(ML, 8'h03, "mod_rw");
    ovf();
    rc(SC, 8'he0, "flag");
    u_cpu.wr(SC, 8'h60);
    rc(SC, 8'h60, "flag_clr");
    chk("irq_low", 8'h00, {7'h00, irq});
    u_cpu.wr(SC, 8'he0);
    rc(SC, 8'h60, "flag_w1");
    ovf();
    u_cpu.wr(SC, 8'h40);
    rc(SC, 8'hc0, "arm");
    repeat (6) @(posedge clk_in);
    u_cpu.wr(SC, 8'h40);
    rc(SC, 8'hc0, "ovf_kept");
    u_cpu.wr(SC, 8'h60);
    rc(SC, 8'he0, "arm");
    @(posedge clk_in) brk <= 1'b1;
    u_cpu.wr(SC, 8'h60);
    rc(SC, 8'he0, "brk_keep");
    @(posedge clk_in) brk <= 1'b0;
    u_cpu.wr(SC, 8'h60);
    rc(SC, 8'h60, "brk_done");
    ovf();
    @(posedge clk_in) {brk, break_flag_clear_enable} <= 2'b11;
    rc(SC, 8'he0, "arm");
    u_cpu.wr(SC, 8'h60);
    @(posedge clk_in) {brk, break_flag_clear_enable} <= 2'b00;
    rc(SC, 8'h60, "break_flag_clear_enable_clr");
    u_cpu.wr(MH, 8'h00);
    u_cpu.wr(SC, 8'h40);
    repeat (20) @(posedge clk_in);
    rc(SC, 8'h40, "pending");
    u_cpu.wr(ML, 8'h03);
    ovf();
    u_cpu.wr(SC, 8'h30);
    u_cpu.wr(MH, 8'hff);
    u_cpu.wr(ML, 8'hff);
    rc(CL, 8'h00, "unlatch");
    // Ticks over 128 clocks for every prescale code.
    for (int s = 0; s < 8; s++) begin
      u_cpu.wr(SC, {5'h02, s[2:0]});
      u_cpu.rd(CL, d0);
      repeat (126) @(posedge clk_in);
      u_cpu.rd(CL, d);
      chk("ps_rate", 8'h80 >> (s == 7 ? 6 : s), d - d0);
    end
    u_cpu.wr(SC, 8'h50);
    u_cpu.rd(CL, d0);
    u_cpu.rd(CH, d);
    repeat (20) @(posedge clk_in);
    u_cpu.rd(CH, d);
    rc(CL, d0 + 8'h02, "latch");
    // Wait, stop and break for 100 edges each.
    for (int m = 0; m < 3; m++) begin
      u_cpu.rd(CL, d0);
      @(posedge clk_in) {wt, st, brk} <= 3'b100 >> m;
      repeat (97) @(posedge clk_in);
      rc(SC, m < 2 ? 8'h00 : 8'hc0, "blocked");
      @(posedge clk_in) {wt, st, brk} <= 3'b000;
      rc(CL, d0 + (m == 0 ? 8'h67 : 8'h03), "freeze");
    end
    // A high-byte read in break keeps the low byte latched after the break ends.
    @(posedge clk_in) brk <= 1'b1;
    u_cpu.rd(CL, d0);
    u_cpu.rd(CH, d);
    @(posedge clk_in) brk <= 1'b0;
    repeat (10) @(posedge clk_in);
    rc(CL, d0, "brk_latch");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
